/* link_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Link side of the register bus: immediate reads and writes on the link clock.
module link_model (
	// Link clock.
	input wire logic ulpi_clk,
	// Register bus towards the bank.
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// The bus starts idle and defined.
	initial begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Address and data are inverted once released, so stale values are never trusted.
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge ulpi_clk);
		reg_addr <= a;
		reg_wdata <= (a == 6'h36 || a == 6'h37) ? (d & 8'hDF) : d;
		reg_wr <= 1'b1;
		@(posedge ulpi_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : write_reg

	// The answer comes exactly one cycle after the strobe and is taken in that cycle.
	task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic ok);
		@(posedge ulpi_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ulpi_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask : read_reg
endmodule : link_model

`default_nettype wire

/* sync_stage.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; only the second flop leaves this module.
module sync_stage #(
	parameter int WIDTH = 1
) (
	// Destination clock.
	input wire logic clk,
	// Asynchronous level in, synchronised level out.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// No reset: the pair settles within two edges of any clock running.
	always_ff @(posedge clk) begin
		meta_r <= async_in;
		sync_out <= meta_r;
	end

endmodule : sync_stage

`default_nettype wire

/* ulpi_vendor_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module ulpi_vendor_register_bank_tb;
	logic mclk = 1'b0;
	logic ulpi_clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid;
	logic carkit_irq_en = 1'b0;
	logic carkit_status_rd = 1'b0;
	logic carkit_latch_rd = 1'b0;
	logic [2:0] id_res_result;
	logic id_conv_done, id_conv_latch, alt_int, id_conv_busy;
	logic uart_tx_enable = 1'b0;
	logic audio_mode = 1'b0;
	logic [2:0] id_res_class = 3'h0;
	logic [1:0] hs_boost, ldo_level, m;
	logic headset_audio_key_match, diff_pin_swap, chg_pullup_plus, chg_pullup_minus;
	logic [7:0] d, io, ce;
	logic [2:0] cls;
	logic irq, en;
	int err_total = 0;
	int tests_run = 0;
	int i, n, n0;
	int busy_cnt = 0;
	// Conversion length used by the bench; the expected busy time is taken from it.
	localparam int CONV_N = 20;

	// Core clock, and a link clock with a one-time phase offset so edges never meet.
	always #2.5 mclk = ~mclk;
	always begin
		if ($time == 0) #1.3;
		#32 ulpi_clk = ~ulpi_clk;
	end

	// Counts core cycles with the converter busy; it is only read as a difference.
	always @(posedge mclk) begin
		if (id_conv_busy === 1'b1) busy_cnt <= busy_cnt + 1;
	end

	// A short conversion count keeps the run brief.
	vendor_reg_bank #(.CONV_CYCLES(CONV_N)) u_dut (.mclk, .rst, .ulpi_clk, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .carkit_irq_en, .carkit_status_rd,
		.carkit_latch_rd, .id_res_result, .id_conv_done, .id_conv_latch, .alt_int,
		.uart_tx_enable, .audio_mode, .id_res_class, .hs_boost, .headset_audio_key_match,
		.diff_pin_swap, .chg_pullup_plus, .chg_pullup_minus, .ldo_level, .id_conv_busy);

	link_model u_link (.ulpi_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_rvalid);

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// A read must answer with valid set, then the data is compared.
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] v;
		logic ok;
		u_link.read_reg(a, v, ok);
		chk({7'h00, ok}, 8'h01);
		chk(v, exp);
	endtask : rchk

	// One carkit strobe: status mirror read or latch read.
	task automatic pulse_ck(input logic latch);
		@(posedge ulpi_clk);
		carkit_status_rd <= ~latch;
		carkit_latch_rd <= latch;
		@(posedge ulpi_clk);
		carkit_status_rd <= 1'b0;
		carkit_latch_rd <= 1'b0;
		@(posedge ulpi_clk);
		#1;
	endtask : pulse_ck

	// Audio wins over UART, otherwise the mode picks the level field.
	function automatic logic [1:0] exp_ldo(logic [7:0] r, logic u, logic a);
		return a ? 2'h0 : (u ? r[3:2] : r[7:6]);
	endfunction : exp_ldo

	// Main sequence; reset also spans four link edges so the link side sees it.
	initial begin
		void'($urandom(32'hFD890EB1));
		repeat (12) @(posedge mclk);
		repeat (4) @(posedge ulpi_clk);
		@(posedge mclk) rst <= 1'b0;
		repeat (4) @(posedge ulpi_clk);
		rchk(6'h31, 8'h00);
		rchk(6'h33, 8'h00);
		for (i = 0; i < 3; i++) rchk(6'h36 + 6'(i), 8'h00);
		for (i = 0; i < 3; i++) rchk(6'h39 + 6'(i), 8'h04);
		rchk(6'h30, 8'h00);
		chk({6'h00, ldo_level}, 8'h00);
		$display("test reset values done");
		for (i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'hFA : 8'($urandom);
			u_link.write_reg(6'h31, d);
			u_link.write_reg(6'h33, d);
			rchk(6'h31, d & 8'h60);
			rchk(6'h33, d & 8'h0F);
			repeat (2) @(posedge ulpi_clk);
			chk({6'h00, hs_boost}, {6'h00, d[6:5]});
			chk({7'h00, headset_audio_key_match}, {7'h00, d[3:0] == 4'hA});
		end
		$display("test boost and audio key done");
		io = 8'h04;
		for (i = 0; i < 12; i++) begin
			d = 8'($urandom);
			m = 2'($urandom);
			if (i % 3 == 0) io = d & 8'hFE;
			else if (i % 3 == 1) io = io | (d & 8'hFE);
			else io = io & ~d;
			u_link.write_reg(6'h39 + 6'(i % 3), d);
			rchk(6'h3B - 6'(i % 3), io);
			@(posedge mclk);
			uart_tx_enable <= m[0];
			audio_mode <= m[1];
			repeat (2) @(posedge ulpi_clk);
			chk({6'h00, ldo_level}, {6'h00, exp_ldo(io, m[0], m[1])});
			chk({7'h00, diff_pin_swap}, {7'h00, io[1]});
			chk({6'h00, chg_pullup_minus, chg_pullup_plus}, {6'h00, io[5:4] | {2{m[0]}}});
		end
		$display("test io and regulator done");
		for (i = 0; i < 4; i++) begin
			cls = (i == 3) ? 3'h7 : 3'($urandom_range(5));
			en = (i == 0) || i[0];
			ce = {1'b0, i == 0, 3'h1, cls};
			@(posedge mclk) id_res_class <= cls;
			@(posedge ulpi_clk) carkit_irq_en <= i[0];
			n0 = busy_cnt;
			if (i[0]) u_link.write_reg(6'h36, 8'h10);
			else u_link.write_reg(6'h37, (i == 0) ? 8'h50 : 8'h10);
			n = 0;
			irq = 1'b0;
			while (id_conv_done !== 1'b1 && n < 200) begin
				@(posedge ulpi_clk);
				#1;
				n++;
				// The pulse stands only in the cycle in which done first shows.
				irq = irq | (alt_int === 1'b1);
			end
			if (n >= 200) begin
				err_total++;
				give_verdict();
			end
			repeat (3) begin
				@(posedge ulpi_clk);
				#1;
				irq = irq | (alt_int === 1'b1);
			end
			chk({7'h00, irq}, {7'h00, en});
			chk({7'h00, id_conv_latch}, {7'h00, en});
			chk({5'h00, id_res_result}, {5'h00, cls});
			chk(8'(busy_cnt - n0), 8'(CONV_N));
			pulse_ck(1'b0);
			chk({7'h00, id_conv_done}, 8'h01);
			rchk(6'h38 - 6'(i[0]), ce);
			chk({7'h00, id_conv_done}, 8'h00);
			rchk(6'h36, ce & 8'hF7);
			pulse_ck(1'b1);
			chk({7'h00, id_conv_latch}, 8'h00);
			u_link.write_reg(6'h38, 8'h40);
			rchk(6'h37, ce & 8'hB7);
		end
		$display("test id conversion done");
		give_verdict();
	end
endmodule : ulpi_vendor_register_bank_tb

`default_nettype wire

/* vendor_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module vendor_reg_bank #(
	parameter int CONV_CYCLES = vendor_regs_pkg::CONV_CYCLES
) (
	// Core clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Link clock.
	input wire logic ulpi_clk,
	// Register access from the link protocol engine, on ulpi_clk.
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Carkit register side, on ulpi_clk.
	input wire logic carkit_irq_en,
	input wire logic carkit_status_rd,
	input wire logic carkit_latch_rd,
	output logic [2:0] id_res_result,
	output logic id_conv_done,
	output logic id_conv_latch,
	output logic alt_int,
	// Mode and converter levels from outside.
	input wire logic uart_tx_enable,
	input wire logic audio_mode,
	input wire logic [2:0] id_res_class,
	// Analogue controls, on mclk.
	output logic [1:0] hs_boost,
	output logic headset_audio_key_match,
	output logic diff_pin_swap,
	output logic chg_pullup_plus,
	output logic chg_pullup_minus,
	output logic [1:0] ldo_level,
	output logic id_conv_busy
);

	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

	typedef enum logic {CONV_IDLE = 1'b0, CONV_BUSY = 1'b1} conv_state_e;

	// ---------------- Link clock domain ----------------
	logic ulpi_rst;
	logic [7:0] boost_r;
	logic [7:0] audio_r;
	logic [7:0] conv_r;
	logic [7:0] io_r;
	logic [7:0] conv_nxt;
	logic [7:0] io_nxt;
	logic req_tgl_r;
	logic done_tgl_s;
	logic done_tgl_prev_r;
	logic [2:0] res_hold_s;
	logic [2:0] res_hold_r;
	logic done_tgl_r;

	// The core reset is carried into the link domain; held reset must span two link edges.
	sync_stage #(.WIDTH(1)) u_rst_sync (
		.clk(ulpi_clk),
		.async_in(rst),
		.sync_out(ulpi_rst)
	);

	// Completion toggle and its result word cross back; the word is stable long before.
	sync_stage #(.WIDTH(1)) u_done_sync (
		.clk(ulpi_clk),
		.async_in(done_tgl_r),
		.sync_out(done_tgl_s)
	);
	assign res_hold_s = res_hold_r;

	// Address decode of the vendor window.
	wire in_vendor = (reg_addr >= vendor_regs_pkg::VENDOR_LO);
	wire wr_boost = reg_wr && reg_addr == vendor_regs_pkg::ADDR_BOOST;
	wire wr_audio = reg_wr && reg_addr == vendor_regs_pkg::ADDR_AUDIO;
	wire wr_conv = reg_wr && reg_addr == vendor_regs_pkg::ADDR_CONV_WR;
	wire set_conv = reg_wr && reg_addr == vendor_regs_pkg::ADDR_CONV_SET;
	wire clr_conv = reg_wr && reg_addr == vendor_regs_pkg::ADDR_CONV_CLR;
	wire wr_io = reg_wr && reg_addr == vendor_regs_pkg::ADDR_IO_WR;
	wire set_io = reg_wr && reg_addr == vendor_regs_pkg::ADDR_IO_SET;
	wire clr_io = reg_wr && reg_addr == vendor_regs_pkg::ADDR_IO_CLR;
	wire rd_conv = reg_rd && reg_addr >= vendor_regs_pkg::ADDR_CONV_WR
		&& reg_addr <= vendor_regs_pkg::ADDR_CONV_CLR;
	wire rd_io = reg_rd && reg_addr >= vendor_regs_pkg::ADDR_IO_WR
		&& reg_addr <= vendor_regs_pkg::ADDR_IO_CLR;
	wire done_evt = done_tgl_s ^ done_tgl_prev_r;
	wire irq_eff = conv_r[vendor_regs_pkg::CONV_IRQ_EN_BIT] | carkit_irq_en;
	wire done_now = conv_r[vendor_regs_pkg::CONV_DONE_BIT];

	// Masked write, set and clear forms; done is hardware owned, result bits take only the 36h write.
	wire [7:0] conv_sc = vendor_regs_pkg::CONV_SC_MASK;
	wire [7:0] conv_wr_val = (conv_r & ~conv_sc) | (reg_wdata & conv_sc);
	wire [7:0] conv_set_val = conv_r | (reg_wdata & conv_sc);
	wire [7:0] conv_clr_val = conv_r & ~(reg_wdata & conv_sc);
	wire [7:0] io_m = vendor_regs_pkg::IO_MASK;
	wire [7:0] io_wr_val = reg_wdata & io_m;
	wire [7:0] io_set_val = io_r | (reg_wdata & io_m);
	wire [7:0] io_clr_val = io_r & ~(reg_wdata & io_m);

	// Result write at 36h lands in bits 2:0; only the write form reaches them.
	wire [7:0] conv_acc = wr_conv ? {conv_wr_val[7:3], reg_wdata[2:0]} :
		set_conv ? conv_set_val : clr_conv ? conv_clr_val : conv_r;
	wire start_rise = !conv_r[vendor_regs_pkg::CONV_START_BIT]
		&& conv_acc[vendor_regs_pkg::CONV_START_BIT];

	// Completion wins over the read clear of done and over a same-cycle start set.
	always_comb begin
		conv_nxt = conv_acc;
		if (rd_conv) begin
			conv_nxt[vendor_regs_pkg::CONV_DONE_BIT] = 1'b0;
		end
		if (done_evt) begin
			conv_nxt[2:0] = res_hold_s;
			conv_nxt[vendor_regs_pkg::CONV_DONE_BIT] = 1'b1;
			conv_nxt[vendor_regs_pkg::CONV_START_BIT] = 1'b0;
		end
		conv_nxt[7] = 1'b0;
	end

	assign io_nxt = wr_io ? io_wr_val : set_io ? io_set_val : clr_io ? io_clr_val : io_r;

	// Read data selection; unmapped vendor and outside addresses answer zero.
	wire [7:0] rd_mux = !in_vendor ? 8'h00 :
		reg_addr == vendor_regs_pkg::ADDR_BOOST ? boost_r :
		reg_addr == vendor_regs_pkg::ADDR_AUDIO ? audio_r :
		rd_conv ? conv_r : rd_io ? io_r : 8'h00;

	// Register storage and the conversion request toggle.
	always_ff @(posedge ulpi_clk) begin
		if (ulpi_rst) begin
			boost_r <= vendor_regs_pkg::BOOST_RST;
			audio_r <= vendor_regs_pkg::AUDIO_RST;
			conv_r <= vendor_regs_pkg::CONV_RST;
			io_r <= vendor_regs_pkg::IO_RST;
			req_tgl_r <= 1'b0;
		end else begin
			if (wr_boost) begin
				boost_r <= reg_wdata & vendor_regs_pkg::BOOST_MASK;
			end
			if (wr_audio) begin
				audio_r <= reg_wdata & vendor_regs_pkg::AUDIO_MASK;
			end
			conv_r <= conv_nxt;
			io_r <= io_nxt;
			req_tgl_r <= req_tgl_r ^ start_rise;
		end
	end

	// Read answer, carkit mirror, latch and alternate interrupt pulse.
	always_ff @(posedge ulpi_clk) begin
		if (ulpi_rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			done_tgl_prev_r <= 1'b0;
			id_conv_latch <= 1'b0;
			alt_int <= 1'b0;
			id_res_result <= 3'h0;
			id_conv_done <= 1'b0;
		end else begin
			reg_rdata <= rd_mux;
			reg_rvalid <= reg_rd;
			done_tgl_prev_r <= done_tgl_s;
			id_conv_latch <= (done_evt && irq_eff && !done_now)
				|| (id_conv_latch && !carkit_latch_rd);
			alt_int <= done_evt && irq_eff;
			id_res_result <= conv_nxt[2:0];
			id_conv_done <= conv_nxt[vendor_regs_pkg::CONV_DONE_BIT];
		end
	end

	a_done_on_finish: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		done_evt |=> conv_r[vendor_regs_pkg::CONV_DONE_BIT] && id_conv_done)
		else $error("done flag not set after conversion end");
	a_start_autoclr: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		done_evt |=> !conv_r[vendor_regs_pkg::CONV_START_BIT])
		else $error("start bit not cleared on completion");
	a_read_clears_done: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		rd_conv && !done_evt |=> !conv_r[vendor_regs_pkg::CONV_DONE_BIT])
		else $error("done flag survived a conversion register read");
	a_mirror_keeps_done: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		carkit_status_rd && !rd_conv && done_now |=> done_now)
		else $error("carkit status read disturbed done");
	a_alt_int_event: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		done_evt && irq_eff |=> alt_int ##1 !alt_int)
		else $error("alternate interrupt not a single pulse on done");
	a_latch_on_rise: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		done_evt && irq_eff && !done_now |=> id_conv_latch)
		else $error("carkit latch missed a done rise");
	a_io_set_or: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		set_io |=> io_r == (($past(io_r) | $past(reg_wdata)) & 8'hFE))
		else $error("set access did not OR data in");
	a_boost_rsvd_zero: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		reg_rd && reg_addr == vendor_regs_pkg::ADDR_BOOST |=> reg_rvalid
		&& reg_rdata[4:0] == 5'h00 && !reg_rdata[7])
		else $error("reserved boost bits read nonzero");
	a_start_launch: assert property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		start_rise |=> req_tgl_r != $past(req_tgl_r))
		else $error("start rise did not launch a conversion");
	c_conv_done: cover property (@(posedge ulpi_clk) disable iff (ulpi_rst) done_evt);
	c_latch_set: cover property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		!id_conv_latch ##1 id_conv_latch);
	c_set_start: cover property (@(posedge ulpi_clk) disable iff (ulpi_rst)
		set_conv && start_rise);

	// ---------------- Core clock domain ----------------
	conv_state_e state_r;
	logic [CW-1:0] cnt_r;
	logic req_s;
	logic req_prev_r;
	logic [4:0] pins_s;
	logic [9:0] cfg_s;

	// Configuration levels change only by software and are read as quasi-static;
	// a two-edge mix of old and new bits is accepted for these analogue controls.
	wire [9:0] cfg_l = {boost_r[6:5],
		audio_r[3:0] == vendor_regs_pkg::AUDIO_KEY,
		io_r[vendor_regs_pkg::SWAP_BIT], io_r[5:4], io_r[3:2], io_r[7:6]};

	sync_stage #(.WIDTH(1)) u_req_sync (
		.clk(mclk),
		.async_in(req_tgl_r),
		.sync_out(req_s)
	);
	sync_stage #(.WIDTH(10)) u_cfg_sync (
		.clk(mclk),
		.async_in(cfg_l),
		.sync_out(cfg_s)
	);
	sync_stage #(.WIDTH(5)) u_pin_sync (
		.clk(mclk),
		.async_in({uart_tx_enable, audio_mode, id_res_class}),
		.sync_out(pins_s)
	);

	wire uart_s = pins_s[4];
	wire audio_s = pins_s[3];
	wire conv_req = req_s ^ req_prev_r;
	wire conv_end = state_r == CONV_BUSY && cnt_r == CONV_LAST;
	// Audio overrides UART, UART overrides the USB modes.
	wire [1:0] ldo_sel = audio_s ? vendor_regs_pkg::LDO_3V3 :
		uart_s ? cfg_s[3:2] : cfg_s[1:0];

	// Conversion timer: a request during a running conversion is absorbed by it.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= CONV_IDLE;
			cnt_r <= '0;
			req_prev_r <= 1'b0;
			done_tgl_r <= 1'b0;
			res_hold_r <= 3'h0;
		end else begin
			req_prev_r <= req_s;
			case (state_r)
				CONV_IDLE: begin
					cnt_r <= '0;
					if (conv_req) begin
						state_r <= CONV_BUSY;
					end
				end
				CONV_BUSY: begin
					cnt_r <= cnt_r + CW'(1);
					if (conv_end) begin
						state_r <= CONV_IDLE;
						res_hold_r <= pins_s[2:0];
						done_tgl_r <= ~done_tgl_r;
					end
				end
				default: state_r <= CONV_IDLE;
			endcase
		end
	end

	// Registered analogue controls.
	always_ff @(posedge mclk) begin
		if (rst) begin
			hs_boost <= 2'h0;
			headset_audio_key_match <= 1'b0;
			diff_pin_swap <= 1'b0;
			chg_pullup_plus <= 1'b0;
			chg_pullup_minus <= 1'b0;
			ldo_level <= vendor_regs_pkg::LDO_3V3;
			id_conv_busy <= 1'b0;
		end else begin
			hs_boost <= cfg_s[9:8];
			headset_audio_key_match <= cfg_s[7];
			diff_pin_swap <= cfg_s[6];
			chg_pullup_plus <= cfg_s[4] | uart_s;
			chg_pullup_minus <= cfg_s[5] | uart_s;
			ldo_level <= ldo_sel;
			id_conv_busy <= state_r == CONV_BUSY;
		end
	end

	a_conv_length: assert property (@(posedge mclk) disable iff (rst)
		conv_end |=> state_r == CONV_IDLE && done_tgl_r != $past(done_tgl_r))
		else $error("conversion did not end on its last cycle");
	a_ldo_audio: assert property (@(posedge mclk) disable iff (rst)
		audio_s |=> ldo_level == vendor_regs_pkg::LDO_3V3)
		else $error("regulator not at 3.3 V in audio mode");
	a_ldo_uart: assert property (@(posedge mclk) disable iff (rst)
		uart_s && !audio_s |=> ldo_level == $past(cfg_s[3:2]))
		else $error("UART regulator level not applied");
	a_pullups_uart: assert property (@(posedge mclk) disable iff (rst)
		uart_s |=> chg_pullup_plus && chg_pullup_minus)
		else $error("charger pull-ups not forced in UART mode");
	c_uart_mode: cover property (@(posedge mclk) disable iff (rst) uart_s ##1 !uart_s);

endmodule : vendor_reg_bank

`default_nettype wire

/* vendor_regs_pkg.sv */
// Shared constants of the vendor register bank: addresses, field positions, resets, timing.
package vendor_regs_pkg;

	// Vendor register window and register addresses on the six-bit immediate address.
	localparam logic [5:0] VENDOR_LO = 6'h30;
	localparam logic [5:0] VENDOR_HI = 6'h3F;
	localparam logic [5:0] ADDR_BOOST = 6'h31;
	localparam logic [5:0] ADDR_AUDIO = 6'h33;
	localparam logic [5:0] ADDR_CONV_WR = 6'h36;
	localparam logic [5:0] ADDR_CONV_SET = 6'h37;
	localparam logic [5:0] ADDR_CONV_CLR = 6'h38;
	localparam logic [5:0] ADDR_IO_WR = 6'h39;
	localparam logic [5:0] ADDR_IO_SET = 6'h3A;
	localparam logic [5:0] ADDR_IO_CLR = 6'h3B;

	// Field positions.
	localparam int BOOST_LSB = 5;
	localparam int CONV_DONE_BIT = 3;
	localparam int CONV_START_BIT = 4;
	localparam int CONV_RSVD_BIT = 5;
	localparam int CONV_IRQ_EN_BIT = 6;
	localparam int SWAP_BIT = 1;
	localparam int UART_LDO_LSB = 2;
	localparam int PULLUP_PLUS_BIT = 4;
	localparam int PULLUP_MINUS_BIT = 5;
	localparam int USB_LDO_LSB = 6;

	// Writable masks; every other bit reads zero, except the conversion register's done and result bits.
	localparam logic [7:0] BOOST_MASK = 8'h60;
	localparam logic [7:0] AUDIO_MASK = 8'h0F;
	localparam logic [7:0] CONV_SC_MASK = 8'h70;
	localparam logic [7:0] IO_MASK = 8'hFE;

	// Reset values.
	localparam logic [7:0] BOOST_RST = 8'h00;
	localparam logic [7:0] AUDIO_RST = 8'h00;
	localparam logic [7:0] CONV_RST = 8'h00;
	localparam logic [7:0] IO_RST = 8'h04;

	// Encodings.
	localparam logic [3:0] AUDIO_KEY = 4'hA;
	localparam logic [1:0] LDO_3V3 = 2'h0;

	// Conversion time and its length in cycles of the 200 MHz clock.
	localparam int CONV_TIME_US = 282;
	localparam int MCLK_MHZ = 200;
	localparam int CONV_CYCLES = CONV_TIME_US * MCLK_MHZ;

endpackage : vendor_regs_pkg
